//--- logic/record_channel_id_inserter.sv
// Channel ID inserter for the record video stream: builds the ID
// payload and writes it into blanking lines as digital and analog IDs.
// Assumes a BT.656 byte stream on the pixel clock with line/field marks;
// all control inputs come from logic on the same clock.
// Behaviour
// - Payload: eight user, eight detection, four auto
// - Auto bytes ordered LT, RT, LB, RB
// - Auto byte fields at fixed bit positions
// - Region-active bit follows quarter region activity
// - New-event bit marks updated channel picture
// - Four detection bits per channel, two bytes
// - Detection bits: loss, motion, blind, night
// - Four bytes per line, two detection lines
// - Detection bytes ordered by cascade stage
// - Non-realtime format: one line, set A first
// - Separate enables for each analog ID kind
// - Programmable line start and two-pixel start
// - Programmable bit width, high and low levels
// - Line: run-in, four bytes, type, parity
// - Type codes zero to five per line
// - Single even parity bit per line
// - Digital line first, analog lines follow
// - Digital ID in luma of one line
// - Indices 0-63, nibble words offset 50h
// - Index map: start, auto, detection, user, end
// - Digital sequence repeats across active line
`timescale 1ns/1ps
module record_channel_id_inserter
  import chid_pkg::*;
#(
  parameter int RUNIN_BITS = RUNIN_BITS_DEF,
  parameter logic [7:0] START_CODE = START_CODE_DEF,
  parameter logic [7:0] END_CODE = END_CODE_DEF
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire video_smp_t VID_I,
  input wire logic VID_VALID_I,
  output logic VID_READY_O,
  output video_smp_t VID_O,
  output logic VID_VALID_O,
  input wire logic VID_READY_I,
  input wire quad_info_t [3:0] QUAD_I,
  input wire logic SEQUENCE_UNIT_SEL_I,
  input wire det_group_t [3:0] DET_I,
  input wire logic ANALOG_SWITCH_SEL_I,
  input wire logic [1:0] CASCADE_STAGE_I,
  input wire logic NONREALTIME_DET_FMT_I,
  input wire logic USER_WR_I,
  input wire logic [2:0] USER_ADDR_I,
  input wire logic [7:0] USER_DATA_I,
  input wire logic AUTO_ID_ENABLE_I,
  input wire logic AUTO_REPEAT_ENABLE_I,
  input wire logic DETECT_ID_ENABLE_I,
  input wire logic USER_ID_ENABLE_I,
  input wire logic RUNIN_ENABLE_I,
  input wire logic DIGITAL_ID_ENABLE_I,
  input wire logic [7:0] ID_LINE_OFFSET_I,
  input wire logic [7:0] ID_PIXEL_OFFSET_I,
  input wire logic [7:0] BIT_PIXEL_WIDTH_I,
  input wire logic [7:0] BIT_HIGH_LEVEL_I,
  input wire logic [7:0] BIT_LOW_LEVEL_I,
  output logic ID_ACTIVE_O
);

  function automatic logic [2:0] next_type(input logic [5:0] en, input logic [2:0] from);
    logic [2:0] r;
    r = TYPE_NONE;
    for (int i = NUM_TYPES - 1; i >= 0; i--) begin
      if (en[i] && (3'(i) >= from)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Payload storage and assembly
  logic [7:0] user_mem_r [8];
  logic [15:0] set_a_r;
  logic [15:0] set_b_r;
  auto_byte_t [3:0] auto_b;
  wire [31:0] auto_word;
  wire [15:0] own_det;
  wire [63:0] det_word;
  wire [63:0] user_word;

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < 8; i++) begin
        user_mem_r[i] <= 8'h00;
      end
    end else if (USER_WR_I) begin
      user_mem_r[USER_ADDR_I] <= USER_DATA_I;
    end
  end

  assign user_word = {user_mem_r[0], user_mem_r[1], user_mem_r[2], user_mem_r[3],
                      user_mem_r[4], user_mem_r[5], user_mem_r[6], user_mem_r[7]};

  generate
    for (genvar q = 0; q < 4; q++) begin : g_auto
      assign auto_b[q].region_active = QUAD_I[q].region_active;
      assign auto_b[q].new_event = QUAD_I[q].new_event;
      assign auto_b[q].sequence_unit_sel = SEQUENCE_UNIT_SEL_I;
      assign auto_b[q].analog_switch_flag = QUAD_I[q].analog_switch_flag;
      assign auto_b[q].cascade_stage = QUAD_I[q].cascade_stage;
      assign auto_b[q].input_path_num = QUAD_I[q].input_path_num;
    end
  endgenerate

  // Quadrant 0 is left top and leaves first
  assign auto_word = {auto_b[0], auto_b[1], auto_b[2], auto_b[3]};

  // Channel 0 in the high nibble of the first byte
  assign own_det = {DET_I[0], DET_I[1], DET_I[2], DET_I[3]};

  // Both analog-switch sets are held so one line can carry eight channels
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      set_a_r <= 16'h0000;
      set_b_r <= 16'h0000;
    end else if (ANALOG_SWITCH_SEL_I) begin
      set_b_r <= own_det;
    end else begin
      set_a_r <= own_det;
    end
  end

  // Other stages' bytes stay zero: cascade data is not merged here
  assign det_word = NONREALTIME_DET_FMT_I ? {set_a_r, set_b_r, 32'h0000_0000}
                  : ({48'h0, own_det} << (DET_STAGE_TOP - {CASCADE_STAGE_I, 4'h0}));

  // Line sequencing
  line_mode_t mode_r;
  line_mode_t mode_nxt;
  logic [LINE_W-1:0] line_cnt_r;
  logic [2:0] tnext_r;
  logic [2:0] ana_type_r;
  logic [LUMA_W-1:0] luma_cnt_r;
  logic [6:0] dig_cnt_r;
  logic [7:0] bit_idx_r;
  logic [7:0] pix_in_bit_r;
  logic id_active_r;

  wire vin_fire;
  wire [LINE_W-1:0] new_line = VID_I.sof ? '0 : line_cnt_r + LINE_W'(1);
  wire [LINE_W-1:0] id_base = LINE_W'(ID_LINE_OFFSET_I);
  wire [LINE_W-1:0] ana_first = id_base + LINE_W'(DIGITAL_ID_ENABLE_I);
  wire [2:0] tfrom = VID_I.sof ? TYPE_AUTO : tnext_r;
  wire det_two = DETECT_ID_ENABLE_I & ~NONREALTIME_DET_FMT_I;
  wire [5:0] type_en = {USER_ID_ENABLE_I, USER_ID_ENABLE_I, det_two, DETECT_ID_ENABLE_I,
                        AUTO_ID_ENABLE_I & AUTO_REPEAT_ENABLE_I, AUTO_ID_ENABLE_I};
  wire [2:0] found = next_type(type_en, tfrom);
  wire dig_here = DIGITAL_ID_ENABLE_I && (new_line == id_base);
  wire ana_here = (new_line >= ana_first) && (found != TYPE_NONE);

  assign mode_nxt = !VID_I.vblank ? MODE_IDLE
                  : dig_here ? MODE_DIGITAL
                  : ana_here ? MODE_ANALOG : MODE_IDLE;

  wire line_start = vin_fire & VID_I.sol;

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      mode_r <= MODE_IDLE;
      line_cnt_r <= '0;
      id_active_r <= 1'b0;
    end else if (line_start) begin
      mode_r <= mode_nxt;
      line_cnt_r <= new_line;
      id_active_r <= (mode_nxt != MODE_IDLE);
    end
  end

  // Pending type restarts at each field so every field carries the full set
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      tnext_r <= TYPE_AUTO;
      ana_type_r <= TYPE_AUTO;
    end else if (line_start && (mode_nxt == MODE_ANALOG)) begin
      ana_type_r <= found;
      tnext_r <= found + 3'h1;
    end else if (line_start) begin
      tnext_r <= tfrom;
    end
  end

  // Analog waveform
  wire [31:0] line_word = (ana_type_r == TYPE_AUTO || ana_type_r == TYPE_AUTO_RPT) ? auto_word
                        : (ana_type_r == TYPE_DET_LO) ? det_word[63:32]
                        : (ana_type_r == TYPE_DET_HI) ? det_word[31:0]
                        : (ana_type_r == TYPE_USER_LO) ? user_word[63:32]
                        : user_word[31:0];
  wire parity = ^{line_word, ana_type_r};
  wire [ANA_CORE_BITS-1:0] ana_core = {line_word, ana_type_r, parity};
  wire [7:0] runin_len = RUNIN_ENABLE_I ? 8'(RUNIN_BITS) : 8'h00;
  wire [7:0] ana_len = runin_len + 8'(ANA_CORE_BITS);
  wire [7:0] core_pos = bit_idx_r - runin_len;
  wire ana_bit = (bit_idx_r < runin_len) ? ~bit_idx_r[0]
               : ana_core[ANA_CORE_MSB - core_pos[5:0]];
  wire [LUMA_W-1:0] hstart = LUMA_W'({ID_PIXEL_OFFSET_I, 1'b0});
  wire ana_on = (mode_r == MODE_ANALOG) && (luma_cnt_r >= hstart) && (bit_idx_r < ana_len);
  // Width zero behaves as one pixel per bit
  wire pix_last = ({1'b0, pix_in_bit_r} + 9'h001) >= {1'b0, BIT_PIXEL_WIDTH_I};
  wire [7:0] ana_level = ana_bit ? BIT_HIGH_LEVEL_I : BIT_LOW_LEVEL_I;

  // Digital words: index word then nibble word, 128 words per pass
  wire [5:0] dig_idx = dig_cnt_r[6:1];
  wire [167:0] dig_vec = {START_CODE, auto_word, det_word, user_word};
  wire [3:0] pay_nib = dig_vec[DIG_VEC_MSB - {dig_idx, 2'b00} -: 4];
  wire [3:0] end_nib = dig_idx[0] ? END_CODE[3:0] : END_CODE[7:4];
  wire [3:0] dig_nib = (dig_idx >= DIG_END_IDX) ? end_nib : pay_nib;
  wire [7:0] dig_word = dig_cnt_r[0] ? (DIG_DATA_OFS + {4'h0, dig_nib})
                      : {2'b00, dig_idx};

  wire is_luma = VID_I.luma & ~VID_I.sol;
  wire dig_sub = is_luma && (mode_r == MODE_DIGITAL);
  wire ana_sub = ~VID_I.sol && ana_on;
  video_smp_t xs;
  assign xs.sof = VID_I.sof;
  assign xs.sol = VID_I.sol;
  assign xs.vblank = VID_I.vblank;
  assign xs.luma = VID_I.luma;
  assign xs.data = dig_sub ? dig_word
                 : (ana_sub && VID_I.luma) ? ana_level
                 : ana_sub ? CHROMA_BLANK : VID_I.data;

  // Luma position since line start; restarts on every accepted line start
  always_ff @(posedge CLK_I) begin
    if (!NRST_I || line_start) begin
      luma_cnt_r <= '0;
    end else if (vin_fire && is_luma) begin
      luma_cnt_r <= luma_cnt_r + LUMA_W'(1);
    end
  end

  // Wraps every 128 luma words so the digital pass repeats along the line
  always_ff @(posedge CLK_I) begin
    if (!NRST_I || line_start) begin
      dig_cnt_r <= 7'h00;
    end else if (vin_fire && is_luma && (mode_r == MODE_DIGITAL)) begin
      dig_cnt_r <= dig_cnt_r + 7'h01;
    end
  end

  // Bits advance only on luma; chroma inside the span is blanked
  wire bit_step = vin_fire && is_luma && ana_on;

  always_ff @(posedge CLK_I) begin
    if (!NRST_I || line_start) begin
      bit_idx_r <= 8'h00;
      pix_in_bit_r <= 8'h00;
    end else if (bit_step) begin
      pix_in_bit_r <= pix_last ? 8'h00 : pix_in_bit_r + 8'h01;
      bit_idx_r <= pix_last ? bit_idx_r + 8'h01 : bit_idx_r;
    end
  end

  // Two-entry skid buffer; outputs and ready straight from flops
  video_smp_t out_r;
  video_smp_t skid_r;
  logic out_vld_r;
  logic skid_vld_r;
  logic ready_r;
  assign vin_fire = VID_VALID_I & ready_r;
  wire drain = ~out_vld_r | VID_READY_I;
  wire skid_vld_nxt = drain ? 1'b0 : (skid_vld_r | vin_fire);
  wire out_vld_nxt = drain ? (skid_vld_r | vin_fire) : 1'b1;

  // Ready from a flop: the skid entry absorbs the word taken while it falls
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      out_vld_r <= 1'b0;
      skid_vld_r <= 1'b0;
      ready_r <= 1'b1;
    end else begin
      out_vld_r <= out_vld_nxt;
      skid_vld_r <= skid_vld_nxt;
      ready_r <= ~skid_vld_nxt;
    end
  end

  // Skid is never full while input is taken, so no word is dropped here
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      out_r <= '0;
      skid_r <= '0;
    end else if (drain) begin
      out_r <= skid_vld_r ? skid_r : xs;
    end else if (vin_fire) begin
      skid_r <= xs;
    end
  end

  assign VID_O = out_r;
  assign VID_VALID_O = out_vld_r;
  assign VID_READY_O = ready_r;
  assign ID_ACTIVE_O = id_active_r;

endmodule // record_channel_id_inserter

//--- logic/chid_pkg.sv
// Constants and carrier types for the record-path channel ID inserter.
// Assumes one pixel clock domain; all users import the whole package.
package chid_pkg;

  localparam int LINE_W = 10;
  localparam int LUMA_W = 11;
  localparam int LINE_BYTES = 4;
  localparam int RUNIN_BITS_DEF = 8;
  localparam int ANA_CORE_BITS = 36;
  localparam logic [5:0] ANA_CORE_MSB = 6'h23;
  localparam int NUM_TYPES = 6;

  localparam logic [2:0] TYPE_AUTO = 3'h0;
  localparam logic [2:0] TYPE_AUTO_RPT = 3'h1;
  localparam logic [2:0] TYPE_DET_LO = 3'h2;
  localparam logic [2:0] TYPE_DET_HI = 3'h3;
  localparam logic [2:0] TYPE_USER_LO = 3'h4;
  localparam logic [2:0] TYPE_USER_HI = 3'h5;
  localparam logic [2:0] TYPE_NONE = 3'h6;

  // Digital ID index map, one nibble per index
  localparam logic [5:0] DIG_AUTO_IDX = 6'h02;
  localparam logic [5:0] DIG_DET_IDX = 6'h0A;
  localparam logic [5:0] DIG_USER_IDX = 6'h1A;
  localparam logic [5:0] DIG_END_IDX = 6'h2A;
  localparam logic [7:0] DIG_DATA_OFS = 8'h50;
  localparam logic [7:0] DIG_VEC_MSB = 8'hA7;
  localparam logic [7:0] START_CODE_DEF = 8'hA5;
  localparam logic [7:0] END_CODE_DEF = 8'hC3;

  localparam logic [7:0] CHROMA_BLANK = 8'h80;
  localparam logic [5:0] DET_STAGE_TOP = 6'h30;

  typedef struct packed {
    logic sof;
    logic sol;
    logic vblank;
    logic luma;
    logic [7:0] data;
  } video_smp_t;

  typedef struct packed {
    logic region_active;
    logic new_event;
    logic analog_switch_flag;
    logic [1:0] cascade_stage;
    logic [1:0] input_path_num;
  } quad_info_t;

  typedef struct packed {
    logic region_active;
    logic new_event;
    logic sequence_unit_sel;
    logic analog_switch_flag;
    logic [1:0] cascade_stage;
    logic [1:0] input_path_num;
  } auto_byte_t;

  typedef struct packed {
    logic signal_loss_flag;
    logic motion_flag;
    logic covered_flag;
    logic dark_flag;
  } det_group_t;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_DIGITAL = 2'b01,
    MODE_ANALOG = 2'b11
  } line_mode_t;

endpackage

//--- dv/chid_monitor.sv
// Checker for the inserter ports: skid occupancy and choice of ID lines.
// Assumes one pixel clock; bound from the bench top.
`timescale 1ns/1ps
module chid_monitor
  import chid_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire video_smp_t VID_I,
  input wire logic VID_VALID_I,
  input wire logic VID_READY_O,
  input wire video_smp_t VID_O,
  input wire logic VID_VALID_O,
  input wire logic VID_READY_I,
  input wire logic AUTO_ID_ENABLE_I,
  input wire logic DIGITAL_ID_ENABLE_I,
  input wire logic [7:0] ID_LINE_OFFSET_I,
  input wire logic ID_ACTIVE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  logic [1:0] occ_r;
  logic [LINE_W-1:0] line_r;
  wire tsol = VID_VALID_I & VID_READY_O & VID_I.sol;
  wire [LINE_W-1:0] nline = VID_I.sof ? '0 : line_r + 1'h1;
  wire [LINE_W-1:0] ofs = LINE_W'(ID_LINE_OFFSET_I);
  wire dig_ln = tsol & VID_I.vblank & DIGITAL_ID_ENABLE_I;
  // Words held inside: accepted in minus accepted out
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      occ_r <= 2'h0;
      line_r <= '0;
    end else begin
      occ_r <= occ_r + 2'(VID_VALID_I & VID_READY_O) - 2'(VID_VALID_O & VID_READY_I);
      if (tsol) line_r <= nline;
    end
  end
  property p_occ; VID_VALID_O == (occ_r != 2'h0); endproperty
  a_occ: assert property (p_occ) else $error("valid vs held count");
  property p_full; VID_READY_O == (occ_r != 2'h2); endproperty
  a_full: assert property (p_full) else $error("ready vs held count");
  property p_hold; VID_VALID_O && !VID_READY_I |=> VID_VALID_O && $stable(VID_O); endproperty
  a_hold: assert property (p_hold) else $error("output moved in stall");
  property p_dig; dig_ln && nline == ofs |=> ID_ACTIVE_O; endproperty
  a_dig: assert property (p_dig) else $error("digital line missing");
  property p_next; dig_ln && AUTO_ID_ENABLE_I && nline == ofs + 1'h1 |=> ID_ACTIVE_O; endproperty
  a_next: assert property (p_next) else $error("analog line not next");
  property p_blank; tsol && !VID_I.vblank |=> !ID_ACTIVE_O; endproperty
  a_blank: assert property (p_blank) else $error("ID in active line");
  property p_early; tsol && nline < ofs |=> !ID_ACTIVE_O; endproperty
  a_early: assert property (p_early) else $error("ID before offset");
  property p_act; $past(NRST_I) && ID_ACTIVE_O != $past(ID_ACTIVE_O) |-> $past(tsol); endproperty
  a_act: assert property (p_act) else $error("active flag off line start");
endmodule // chid_monitor

//--- dv/recorder_model.sv
// Downstream recorder: takes the record stream with periodic stalls.
// Assumes every line opens with a line-start sample.
`timescale 1ns/1ps
module recorder_model
  import chid_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire video_smp_t vid_i,
  input wire logic valid_i,
  output logic ready_o
);
  video_smp_t smp [0:2047];
  int n;
  logic [4:0] cnt_r = 5'h00;
  // Five-cycle stalls fill the skid entry
  assign ready_o = cnt_r > 5'h04;
  always @(posedge clk_i) begin
    cnt_r <= (!nrst_i || cnt_r == 5'h16) ? 5'h00 : cnt_r + 5'h01;
    if (valid_i && ready_o) begin
      smp[vid_i.sol ? 0 : n] <= vid_i;
      n <= vid_i.sol ? 1 : n + 1;
    end
  end
endmodule // recorder_model

//--- dv/record_channel_id_inserter_test.sv
// Bench: sends blanking lines and checks each delivered sample.
// Assumes the recorder model stores the last line it received.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module record_channel_id_inserter_test;
  import chid_pkg::*;
  logic CLK_I, NRST_I, VID_VALID_I, VID_READY_O, VID_VALID_O, VID_READY_I, ID_ACTIVE_O;
  logic SEQUENCE_UNIT_SEL_I, ANALOG_SWITCH_SEL_I, NONREALTIME_DET_FMT_I, USER_WR_I;
  logic AUTO_ID_ENABLE_I, AUTO_REPEAT_ENABLE_I, DETECT_ID_ENABLE_I, USER_ID_ENABLE_I;
  logic RUNIN_ENABLE_I, DIGITAL_ID_ENABLE_I;
  logic [1:0] CASCADE_STAGE_I;
  logic [2:0] USER_ADDR_I;
  logic [7:0] USER_DATA_I, ID_LINE_OFFSET_I, ID_PIXEL_OFFSET_I, BIT_PIXEL_WIDTH_I;
  logic [7:0] BIT_HIGH_LEVEL_I, BIT_LOW_LEVEL_I;
  video_smp_t VID_I, VID_O;
  quad_info_t [3:0] QUAD_I;
  det_group_t [3:0] DET_I;
  logic [7:0] pay [20];
  int n_fail, num_checks, cyc;
  record_channel_id_inserter u_record_channel_id_inserter (.CLK_I, .NRST_I, .VID_I,
    .VID_VALID_I, .VID_READY_O, .VID_O, .VID_VALID_O, .VID_READY_I, .QUAD_I,
    .SEQUENCE_UNIT_SEL_I, .DET_I, .ANALOG_SWITCH_SEL_I, .CASCADE_STAGE_I,
    .NONREALTIME_DET_FMT_I, .USER_WR_I, .USER_ADDR_I, .USER_DATA_I, .AUTO_ID_ENABLE_I,
    .AUTO_REPEAT_ENABLE_I, .DETECT_ID_ENABLE_I, .USER_ID_ENABLE_I, .RUNIN_ENABLE_I,
    .DIGITAL_ID_ENABLE_I, .ID_LINE_OFFSET_I, .ID_PIXEL_OFFSET_I, .BIT_PIXEL_WIDTH_I,
    .BIT_HIGH_LEVEL_I, .BIT_LOW_LEVEL_I, .ID_ACTIVE_O);
  recorder_model u_rec (.clk_i(CLK_I), .nrst_i(NRST_I), .vid_i(VID_O),
    .valid_i(VID_VALID_O), .ready_o(VID_READY_I));
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic put(input video_smp_t s);
    VID_I <= s;
    VID_VALID_I <= 1'b1;
    @(negedge CLK_I);
    while (VID_READY_O !== 1'b1) @(negedge CLK_I);
    @(posedge CLK_I);
  endtask
  function automatic logic [7:0] dword(input int k);
    int x;
    logic [7:0] b;
    x = k / 2 % 64;
    b = x < 2 ? START_CODE_DEF : x < 42 ? pay[(x - 2) / 2] : END_CODE_DEF;
    return k[0] ? 8'h50 + (x[0] ? b[3:0] : b[7:4]) : 8'(x);
  endfunction
  function automatic bit abit(input int t, input int b, input int nb);
    logic [31:0] d;
    logic [43:0] v;
    int s;
    s = t < 2 ? 0 : 4 * t - 4;
    d = {pay[s], pay[s + 1], pay[s + 2], pay[s + 3]};
    v = {8'hAA, d, 3'(t), ^{d, 3'(t)}};
    return v[nb - 1 - b];
  endfunction
  // Mode: below zero plain line, 0 to 5 analog type, 8 digital
  task automatic line(input bit sof, input bit vb, input int n, input int m);
    video_smp_t e;
    int k, st, nb, w;
    for (int i = 0; i < n; i++) put('{sof && i == 0, i == 0, vb, i[0], i[0] ? 8'h20 : 8'h33});
    VID_VALID_I <= 1'b0;
    for (int j = 0; j < 99 && u_rec.n != n; j++) @(posedge CLK_I);
    st = 2 * ID_PIXEL_OFFSET_I;
    w = BIT_PIXEL_WIDTH_I;
    nb = (RUNIN_ENABLE_I ? RUNIN_BITS_DEF : 0) + ANA_CORE_BITS;
    for (int i = 0; i < n; i++) begin
      e = '{sof && i == 0, i == 0, vb, i[0], i[0] ? 8'h20 : 8'h33};
      // Luma samples already passed since the line start
      k = i / 2;
      if (m == 8 && i[0]) e.data = dword(k);
      if (m >= 0 && m < 8 && i > 0 && k >= st && k < st + nb * w) begin
        e.data = abit(m, (k - st) / w, nb) ? BIT_HIGH_LEVEL_I : BIT_LOW_LEVEL_I;
        if (!i[0]) e.data = CHROMA_BLANK;
      end
      if (m < 0) `CHK("plain", e, u_rec.smp[i])
      if (m == 8) `CHK("digital", e, u_rec.smp[i])
      if (m >= 0 && m < 8) `CHK("analog", e, u_rec.smp[i])
    end
    `CHK("active", m >= 0, ID_ACTIVE_O)
  endtask
  initial begin
    {NRST_I, VID_VALID_I, USER_WR_I, USER_ADDR_I, USER_DATA_I, ANALOG_SWITCH_SEL_I} = '0;
    NONREALTIME_DET_FMT_I = 1'b0;
    {AUTO_ID_ENABLE_I, AUTO_REPEAT_ENABLE_I, DETECT_ID_ENABLE_I} = '1;
    {USER_ID_ENABLE_I, RUNIN_ENABLE_I, DIGITAL_ID_ENABLE_I} = '1;
    VID_I = '0;
    SEQUENCE_UNIT_SEL_I = 1'b1;
    CASCADE_STAGE_I = 2'h1;
    QUAD_I = {7'h1C, 7'h63, 7'h29, 7'h56};
    DET_I = 16'hA741;
    ID_LINE_OFFSET_I = 8'h02;
    ID_PIXEL_OFFSET_I = 8'h03;
    BIT_PIXEL_WIDTH_I = 8'h03;
    BIT_HIGH_LEVEL_I = 8'hB0;
    BIT_LOW_LEVEL_I = 8'h10;
    // Auto bytes LT..RB, then stage 1 detection pair
    pay = '{0: 8'hB6, 1: 8'h69, 2: 8'hE3, 3: 8'h3C, 6: 8'h14, 7: 8'h7A, default: 8'h00};
    repeat (20) @(posedge CLK_I);
    NRST_I <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      USER_WR_I <= 1'b1;
      USER_ADDR_I <= 3'(a);
      USER_DATA_I <= 8'(a * 37 + 15);
      pay[12 + a] = 8'(a * 37 + 15);
      @(posedge CLK_I);
    end
    USER_WR_I <= 1'b0;
    line(1, 1, 41, -1);
    line(0, 1, 41, -1);
    line(0, 1, 1441, 8);
    for (int t = 0; t < 6; t++) begin
      line(0, 1, 301, t);
    end
    line(0, 1, 301, -1);
    line(0, 0, 41, -1);
    {AUTO_ID_ENABLE_I, USER_ID_ENABLE_I, RUNIN_ENABLE_I, DIGITAL_ID_ENABLE_I} <= '0;
    NONREALTIME_DET_FMT_I <= 1'b1;
    ID_LINE_OFFSET_I <= 8'h01;
    ID_PIXEL_OFFSET_I <= 8'h05;
    BIT_PIXEL_WIDTH_I <= 8'h02;
    BIT_HIGH_LEVEL_I <= 8'hC8;
    DET_I <= 16'h2C58;
    ANALOG_SWITCH_SEL_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    pay[4] = 8'h14;
    pay[5] = 8'h7A;
    pay[6] = 8'h85;
    pay[7] = 8'hC2;
    line(1, 1, 41, -1);
    line(0, 1, 201, 2);
    line(0, 1, 201, -1);
    wrap_up;
  end
endmodule // record_channel_id_inserter_test
bind record_channel_id_inserter chid_monitor u_chid_monitor (.CLK_I, .NRST_I, .VID_I,
  .VID_VALID_I, .VID_READY_O, .VID_O, .VID_VALID_O, .VID_READY_I, .AUTO_ID_ENABLE_I,
  .DIGITAL_ID_ENABLE_I, .ID_LINE_OFFSET_I, .ID_ACTIVE_O);
